/* common/hpc_pkg.sv */
package hpc_pkg;

  // =====================================================================
  // Port change word layout
  localparam int unsigned CHG_W        = 16;
  localparam int unsigned BIT_CONNECT  = 0;
  localparam int unsigned BIT_OVERCUR  = 3;
  localparam int unsigned BIT_RESET    = 4;
  localparam int unsigned BIT_WARM     = 5;
  localparam int unsigned BIT_LINK     = 6;
  localparam int unsigned BIT_CFGERR   = 7;
  localparam logic [15:0] CHG_RESET_VAL = 16'h0000;
  localparam logic [15:0] CHG_IMPL_MASK = 16'h00f9;

  // =====================================================================
  // Feature selectors of the change flags
  localparam logic [7:0] SEL_C_CONNECT = 8'h10;
  localparam logic [7:0] SEL_C_OVERCUR = 8'h13;
  localparam logic [7:0] SEL_C_RESET   = 8'h14;
  localparam logic [7:0] SEL_C_LINK    = 8'h19;
  localparam logic [7:0] SEL_C_CFGERR  = 8'h1a;
  localparam logic [7:0] SEL_C_WARM    = 8'h1d;

  // =====================================================================
  // Downstream port states as reported by the port state machine
  typedef enum logic [2:0] {
    HPC_PS_POWERED_OFF,
    HPC_PS_DISCONNECTED,
    HPC_PS_TRAINING,
    HPC_PS_ENABLED,
    HPC_PS_RESETTING,
    HPC_PS_ERROR,
    HPC_PS_DISABLED
  } hpc_port_state_e;

  // Link events from the link layer, each a one-cycle pulse
  typedef struct packed {
    logic u3_to_u0_sw;
    logic u3_to_u0_remote;
    logic to_inactive;
    logic config_fail;
  } hpc_link_evt_s;

  // Feature request from the control-request decoder
  typedef struct packed {
    logic       valid;
    logic       set;
    logic [7:0] selector;
  } hpc_feat_req_s;

endpackage : hpc_pkg

/* rtl/hpc_port_change.sv */
// Contract
// - Each change flag stays set until its clear request or a hub reset; bits 3-7 also clear while powered off.
// - Set requests on change flags: optional diagnostic set, else error or no-op.
// - Bit 0 reads 1 after a connect status change, else 0.
// - Bits 1-2 and 8-15 are reserved and read zero.
// - Bit 3 reads zero on hubs without per-port over-current reporting.
// - Over-current flag sets on each edge of over-current status or forced power-off.
// - Over-current flag clears by request and holds zero while powered off.
// - Bit 4 sets on resetting-to-enabled after any reset.
// - Bit 5 sets on resetting-to-enabled only after a warm reset.
// - Reset, warm, link and config flags clear by request, zero while power off.
// - Bit 6 sets on software U3-to-U0 completion or entry into SS.Inactive.
// - Bit 6 does not set on remote-wakeup U3-to-U0 return.
// - Bit 7 sets when the port cannot configure its link partner.
// - A flagged configuration error also sends the port to disabled.
// - Connect flag sets when training ends and the port enters enabled.
// - Connection status is one while enabled, resetting or error.
// - Logical power zero means powered-off; forced power-off clears power.
`timescale 1ns/100ps
`default_nettype none

module hpc_port_change #(
  parameter bit PER_PORT_OC  = 1'b1,
  parameter bit DIAG_SET_OK  = 1'b0
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire hpc_pkg::hpc_port_state_e port_state,
  input  wire logic                    warm_reset_active,
  input  wire logic                    over_current_pin,
  input  wire logic                    forced_off_by_other,
  input  wire logic                    logical_power,
  input  wire hpc_pkg::hpc_link_evt_s  link_evt,
  input  wire hpc_pkg::hpc_feat_req_s  feat_req,
  output logic [15:0]                  port_change_word,
  output logic                         connection_status_bit,
  output logic                         over_current_status,
  output logic                         force_disable,
  output logic                         force_power_off,
  output logic                         req_error
);

  // =====================================================================
  // Parameter check
  if (hpc_pkg::CHG_W != 16) begin : g_bad_width
    $error("port change word must be 16 bits");
  end

  // Every flag position must fall inside the word
  if (hpc_pkg::BIT_CFGERR >= hpc_pkg::CHG_W) begin : g_bad_layout
    $error("change flag outside the port change word");
  end

  // =====================================================================
  // Over-current pin synchroniser and edge history
  logic oc_meta;
  logic oc_sync;
  logic oc_prev;
  logic next_oc_meta;
  logic next_oc_sync;
  logic next_oc_prev;

  always_comb begin
    next_oc_meta = over_current_pin;
    next_oc_sync = oc_meta;
    next_oc_prev = oc_sync;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oc_meta <= 1'b0;
      oc_sync <= 1'b0;
      oc_prev <= 1'b0;
    end else begin
      oc_meta <= next_oc_meta;
      oc_sync <= next_oc_sync;
      oc_prev <= next_oc_prev;
    end
  end

  // =====================================================================
  // Port state history and warm-reset capture
  hpc_pkg::hpc_port_state_e prev_state;
  hpc_pkg::hpc_port_state_e next_prev_state;
  logic                     warm_seen;
  logic                     next_warm_seen;

  always_comb begin
    next_prev_state = port_state;
    next_warm_seen  = warm_seen;
    if (port_state == hpc_pkg::HPC_PS_RESETTING && warm_reset_active) begin
      next_warm_seen = 1'b1;
    end else if (port_state != hpc_pkg::HPC_PS_RESETTING) begin
      next_warm_seen = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prev_state <= hpc_pkg::HPC_PS_POWERED_OFF;
      warm_seen  <= 1'b0;
    end else begin
      prev_state <= next_prev_state;
      warm_seen  <= next_warm_seen;
    end
  end

  // =====================================================================
  // Events
  logic reset_done;
  logic [15:0] set_evt;
  logic [15:0] clr_req;
  logic [15:0] diag_set;
  logic        sel_known;
  logic        power_off;

  assign power_off = !logical_power || port_state == hpc_pkg::HPC_PS_POWERED_OFF;

  always_comb begin
    reset_done = prev_state == hpc_pkg::HPC_PS_RESETTING
              && port_state == hpc_pkg::HPC_PS_ENABLED;
    set_evt = '0;
    set_evt[hpc_pkg::BIT_CONNECT] = prev_state == hpc_pkg::HPC_PS_TRAINING
                                 && port_state == hpc_pkg::HPC_PS_ENABLED;
    set_evt[hpc_pkg::BIT_OVERCUR] = (oc_sync != oc_prev) || forced_off_by_other;
    set_evt[hpc_pkg::BIT_RESET]   = reset_done;
    set_evt[hpc_pkg::BIT_WARM]    = reset_done && (warm_seen || warm_reset_active);
    // A wake-up return from U3 driven by the device must not raise the link flag
    set_evt[hpc_pkg::BIT_LINK]    = (link_evt.u3_to_u0_sw && !link_evt.u3_to_u0_remote)
                                 || link_evt.to_inactive;
    set_evt[hpc_pkg::BIT_CFGERR]  = link_evt.config_fail;

    sel_known = 1'b1;
    clr_req   = '0;
    // Decode the selector first; whether it clears or sets is decided below
    case (feat_req.selector)
      hpc_pkg::SEL_C_CONNECT: begin
        clr_req[hpc_pkg::BIT_CONNECT] = 1'b1;
      end
      hpc_pkg::SEL_C_OVERCUR: begin
        clr_req[hpc_pkg::BIT_OVERCUR] = 1'b1;
      end
      hpc_pkg::SEL_C_RESET: begin
        clr_req[hpc_pkg::BIT_RESET] = 1'b1;
      end
      hpc_pkg::SEL_C_WARM: begin
        clr_req[hpc_pkg::BIT_WARM] = 1'b1;
      end
      hpc_pkg::SEL_C_LINK: begin
        clr_req[hpc_pkg::BIT_LINK] = 1'b1;
      end
      hpc_pkg::SEL_C_CFGERR: begin
        clr_req[hpc_pkg::BIT_CFGERR] = 1'b1;
      end
      default: begin
        // Selectors of other features are not ours to serve
        sel_known = 1'b0;
      end
    endcase
    // Diagnostic set only when enabled; otherwise a set leaves the flags alone and raises req_error
    diag_set = (feat_req.valid && feat_req.set && DIAG_SET_OK) ? clr_req : '0;
    if (!(feat_req.valid && !feat_req.set)) begin
      clr_req = '0;
    end
  end

  // =====================================================================
  // Change flags
  logic [15:0] flags;
  logic [15:0] next_flags;
  logic        err_q;
  logic        next_err;

  always_comb begin
    // Clear before set so a coincident event survives
    next_flags = (flags & ~clr_req) | set_evt | diag_set;
    if (power_off) begin
      next_flags[hpc_pkg::BIT_OVERCUR] = 1'b0;
      next_flags[hpc_pkg::BIT_RESET]   = 1'b0;
      next_flags[hpc_pkg::BIT_WARM]    = 1'b0;
      next_flags[hpc_pkg::BIT_LINK]    = 1'b0;
      next_flags[hpc_pkg::BIT_CFGERR]  = 1'b0;
    end
    if (!PER_PORT_OC) begin
      next_flags[hpc_pkg::BIT_OVERCUR] = 1'b0;
    end
    // Reserved positions are forced low last so no path can leak into them
    next_flags = next_flags & hpc_pkg::CHG_IMPL_MASK;
    // Unsupported set on a change flag, or unknown selector, is a request error
    next_err = feat_req.valid && (!sel_known || (feat_req.set && !DIAG_SET_OK));
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags <= hpc_pkg::CHG_RESET_VAL;
      err_q <= 1'b0;
    end else begin
      flags <= next_flags;
      err_q <= next_err;
    end
  end

  // =====================================================================
  // Outputs
  assign port_change_word = flags;
  assign req_error        = err_q;
  assign connection_status_bit = port_state == hpc_pkg::HPC_PS_ENABLED
                              || port_state == hpc_pkg::HPC_PS_RESETTING
                              || port_state == hpc_pkg::HPC_PS_ERROR;
  assign over_current_status = oc_sync;
  // Left combinational so the port leaves the enabled state in the event cycle
  assign force_disable       = link_evt.config_fail;
  assign force_power_off     = forced_off_by_other;

endmodule : hpc_port_change

`default_nettype wire

/* verif/hpc_port_change_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module hpc_port_change_sva #(
  parameter bit PER_PORT_OC = 1'b1
) (
  input wire logic                     ref_clk,
  input wire logic                     reset,
  input wire hpc_pkg::hpc_port_state_e port_state,
  input wire logic                     warm_reset_active,
  input wire logic                     logical_power,
  input wire logic                     forced_off_by_other,
  input wire logic                     force_power_off,
  input wire hpc_pkg::hpc_link_evt_s   link_evt,
  input wire hpc_pkg::hpc_feat_req_s   feat_req,
  input wire logic [15:0]              port_change_word,
  input wire logic                     connection_status_bit,
  input wire logic                     over_current_status,
  input wire logic                     force_disable,
  input wire logic                     req_error
);
  // ===================================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Power-off hold beats every set on bits 3-7, so set checks only apply while powered
  wire logic live = logical_power && port_state != hpc_pkg::HPC_PS_POWERED_OFF;
  rsv_zero_a: assert property (port_change_word[15:8] == 8'h00 && !port_change_word[2:1])
    else $error("reserved bit set");
  conn_stat_a: assert property (connection_status_bit == (port_state inside
      {hpc_pkg::HPC_PS_ENABLED, hpc_pkg::HPC_PS_RESETTING, hpc_pkg::HPC_PS_ERROR}))
    else $error("connection status wrong");
  rst_done_a: assert property ($past(port_state) == hpc_pkg::HPC_PS_RESETTING && live &&
      port_state == hpc_pkg::HPC_PS_ENABLED |=> port_change_word[4]
      && (port_change_word[5] || !$past(warm_reset_active))) else $error("reset flags lost");
  remote_a: assert property (link_evt == 4'b0100 && !port_change_word[6] |=>
      !port_change_word[6]) else $error("remote wake set link flag");
  link_a: assert property ((link_evt.u3_to_u0_sw || link_evt.to_inactive) && live |=>
      port_change_word[6]) else $error("link flag not set");
  cfg_a: assert property (link_evt.config_fail && live |=> port_change_word[7])
    else $error("config flag not set");
  disable_a: assert property (force_disable == link_evt.config_fail)
    else $error("disable not forced");
  oc_edge_a: assert property ($changed(over_current_status) && live |=>
      port_change_word[3] == PER_PORT_OC) else $error("over-current flag wrong");
  oc_force_a: assert property (forced_off_by_other && live |=>
      port_change_word[3] == PER_PORT_OC) else $error("forced off not flagged");
  pwr_force_a: assert property (force_power_off == forced_off_by_other)
    else $error("power off not forced");
  off_hold_a: assert property (!logical_power |=> port_change_word[7:3] == 5'h00)
    else $error("flags kept while off");
  conn_hold_a: assert property (port_change_word[0] && !(feat_req.valid &&
      feat_req.selector == hpc_pkg::SEL_C_CONNECT) |=> port_change_word[0])
    else $error("connect flag dropped");
  set_err_a: assert property (feat_req.valid && feat_req.set |=> req_error)
    else $error("set request not refused");
  cover property (port_change_word[5:4] == 2'b11);
  cover property (req_error);
  cover property (!logical_power && port_change_word[0]);
endmodule : hpc_port_change_sva
bind hpc_port_change hpc_port_change_sva #(.PER_PORT_OC(PER_PORT_OC)) chk (.*);
`default_nettype wire

/* verif/hpc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hpc_host_model (
  input wire logic                    ref_clk,
  output var hpc_pkg::hpc_feat_req_s  feat_req
);
  // ===================================================================
  // Requests last exactly one cycle, returning at the check point after
  initial feat_req = '0;
  task automatic send(input logic set, input logic [7:0] sel);
    @(negedge ref_clk);
    feat_req <= '{1'b1, set, sel};
    @(negedge ref_clk);
    feat_req <= '0;
  endtask : send
endmodule : hpc_host_model
`default_nettype wire

/* verif/hpc_port_change_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module hpc_port_change_bench;
  logic                     ref_clk, reset, warm, oc_pin, fo, power, req_error;
  hpc_pkg::hpc_port_state_e state;
  hpc_pkg::hpc_link_evt_s   evt;
  hpc_pkg::hpc_feat_req_s   req;
  logic [15:0]              word, expw;
  logic [16:0]              notes[$];
  int                       n_mismatch, num_checks;
  event                     look;
  hpc_port_change dut (.ref_clk, .reset, .port_state(state), .warm_reset_active(warm),
    .over_current_pin(oc_pin), .forced_off_by_other(fo), .logical_power(power), .link_evt(evt),
    .feat_req(req), .port_change_word(word), .connection_status_bit(), .over_current_status(),
    .force_disable(), .force_power_off(), .req_error);
  hpc_host_model host (.ref_clk, .feat_req(req));
  // ===================================================================
  // Clock, scoreboard and closing
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic note(input logic err);
    notes.push_back({err, expw});
    -> look;
  endtask : note
  always @(look) begin
    logic [16:0] e;
    e = notes.pop_front();
    num_checks++;
    if ({req_error, word} !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, {req_error, word}, e);
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    #3000;
    n_mismatch++;
    complete_run();
  end
  // ===================================================================
  // Scenarios
  initial begin
    void'($urandom(32'hc33532c6));
    {reset, warm, oc_pin, fo, power} = 5'b10001;
    evt = '0;
    state = hpc_pkg::HPC_PS_DISCONNECTED;
    expw = '0;
    tick(4);
    reset = 0;
    tick(1); note(0);
    state = hpc_pkg::HPC_PS_TRAINING;
    tick(1);
    state = hpc_pkg::HPC_PS_ENABLED;
    tick(1); expw[0] = 1; note(0);
    for (int i = 0; i < 2; i++) begin
      state = hpc_pkg::HPC_PS_RESETTING;
      warm = i[0];
      tick(1 + $urandom % 4);
      state = hpc_pkg::HPC_PS_ENABLED;
      tick(1); expw[4] = 1; expw[5] |= i[0]; note(0);
      if (i == 0) begin
        host.send(0, hpc_pkg::SEL_C_RESET); expw[4] = 0; note(0);
      end
    end
    evt = 4'b0100;
    tick(1); evt = '0; note(0);
    evt = 4'b1000;
    tick(1); evt = '0; expw[6] = 1; note(0);
    host.send(0, hpc_pkg::SEL_C_LINK); expw[6] = 0; note(0);
    evt = 4'b0011;
    tick(1); evt = '0; expw[7:6] = 2'b11; note(0);
    oc_pin = 1;
    tick(5); expw[3] = 1; note(0);
    host.send(1, hpc_pkg::SEL_C_RESET); note(1);
    host.send(0, {1'b1, 7'($urandom)}); note(1);
    host.send(0, hpc_pkg::SEL_C_OVERCUR); expw[3] = 0; note(0);
    host.send(0, hpc_pkg::SEL_C_WARM); expw[5] = 0; note(0);
    fo = 1;
    tick(1); fo = 0; expw[3] = 1; note(0);
    // Pin edge while off must not survive the power-off hold
    power = 0;
    oc_pin = 0;
    tick(5); expw[7:3] = 0; note(0);
    host.send(0, hpc_pkg::SEL_C_CFGERR); note(0);
    host.send(0, hpc_pkg::SEL_C_CONNECT); expw[0] = 0; note(0);
    tick(1);
    complete_run();
  end
endmodule : hpc_port_change_bench
`default_nettype wire
